// ==== share_guard_params.svh ====
// Constants for the peripheral sharing access guard.
// Assumes inclusion by bare name from the package and the guard module.
`ifndef SHARE_GUARD_PARAMS_SVH
`define SHARE_GUARD_PARAMS_SVH

// Port counts and widths
`define SG_NPER      5
`define SG_NHOST     4
`define SG_SEL_W     2
`define SG_PIDX_W    3
`define SG_ID_W      16
`define SG_PROTO_W   4
`define SG_NPROTO    16
`define SG_DATA_W    8
`define SG_LIST_LEN  4
`define SG_LIDX_W    2

// Peripheral port indices
`define SG_PORT_KBD   3'h0
`define SG_PORT_MOUSE 3'h1
`define SG_PORT_DISP0 3'h2
`define SG_PORT_DISP1 3'h3
`define SG_PORT_AUDIO 3'h4

// Allowed protocol masks, one bit per protocol code
`define SG_PROTO_MASK_KBD   16'h0002
`define SG_PROTO_MASK_MOUSE 16'h0002
`define SG_PROTO_MASK_DISP  16'h0030
`define SG_PROTO_MASK_AUDIO 16'h0100

// Default filter lists, entry 0 in the low bits
`define SG_BLOCK_LIST_RST 64'hffff_ffff_ffff_ffff
`define SG_ALLOW_LIST_RST 64'h0004_0003_0002_0001

// Egress format per peripheral port: 1 keeps the internal word
`define SG_OUT_CONV_DEF 5'h0c

// Reset values
`define SG_SEL_RST    2'h0
`define SG_ATTACH_RST 5'h00

`endif

// ==== share_guard_pkg.sv ====
// Types shared by the access guard and its bench.
// Assumes share_guard_params.svh in the same folder.
`include "share_guard_params.svh"
`default_nettype none

package share_guard_pkg;

  typedef logic [`SG_PIDX_W-1:0]  pidx_t;
  typedef logic [`SG_SEL_W-1:0]   hsel_t;
  typedef logic [`SG_ID_W-1:0]    dev_id_t;
  typedef logic [`SG_PROTO_W-1:0] proto_t;
  typedef logic [`SG_DATA_W-1:0]  data_t;

  // Enumeration result of one peripheral
  typedef struct packed {
    dev_id_t dev_id;
    proto_t  proto;
  } desc_t;

  // Internal word: protocol tag plus payload
  typedef struct packed {
    proto_t tag;
    data_t  data;
  } word_t;

  // Beat from a peripheral toward the selected host
  typedef struct packed {
    logic  valid;
    pidx_t port;
    data_t data;
  } per_rx_t;

  // Beat from the hosts toward a peripheral
  typedef struct packed {
    logic [`SG_NHOST-1:0] valid;
    pidx_t                port;
    data_t                data;
  } host_rx_t;

  typedef struct packed {
    logic [`SG_NHOST-1:0] valid;
    word_t                word;
  } host_tx_t;

  typedef struct packed {
    logic [`SG_NPER-1:0] valid;
    word_t               word;
  } per_tx_t;

  // Filter list write
  typedef struct packed {
    logic                   we;
    logic                   allow;
    logic [`SG_LIDX_W-1:0]  idx;
    dev_id_t                dev_id;
  } cfg_t;

  typedef logic [`SG_LIST_LEN-1:0][`SG_ID_W-1:0] list_t;

endpackage

`default_nettype wire

// ==== peripheral_share_access_guard.sv ====
// Access guard between shared peripherals and the connected hosts.
// Assumes enumeration logic on clk supplies a stable descriptor per port
// while its attach pin is high; select, attach and fail come from pins.
`include "share_guard_params.svh"
`default_nettype none

// Functional notes
// [R01] Forward only between selected host and ports
// [R02] No path ever joins two hosts
// [R03] Failure state blocks every data path
// [R04] Refuse unauthorized peripheral at power-up, hot-plug
// [R05] Refuse peripheral with unauthorized interface protocol
// [R06] Drive user indication on every refusal
// [R07] Block list match means unauthorized
// [R08] Allow list counts only without block match
// [R09] Accept authorized type with authorized protocol
// [R10] Audio port power off when unauthorized
// [R11] Filter lists fixed or configurable by parameter
// [R12] One or several displays by parameter
// [R13] Convert ingress; egress format chosen per interface
// [R14] Failure latches until next power-on reset
module peripheral_share_access_guard #(
  parameter bit                  FILTER_CFG    = 1'b0,
  parameter bit                  MULTI_DISPLAY = 1'b1,
  parameter logic [`SG_NPER-1:0] OUT_CONVERTED = `SG_OUT_CONV_DEF
) (
  // Clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // User and board pins
  input  wire logic [`SG_SEL_W-1:0]          sel_pin,
  input  wire logic [`SG_NPER-1:0]           attach_pin,
  input  wire logic                          fail_pin,
  // Enumeration results
  input  wire share_guard_pkg::desc_t [`SG_NPER-1:0] desc,
  // Filter list writes
  input  wire share_guard_pkg::cfg_t         cfg,
  // Data in
  input  wire share_guard_pkg::per_rx_t      per_rx,
  input  wire share_guard_pkg::host_rx_t     host_rx,
  // Data out
  output var  share_guard_pkg::host_tx_t     host_tx,
  output var  share_guard_pkg::per_tx_t      per_tx,
  // Indications and power
  output logic [`SG_NPER-1:0]                port_enable,
  output logic [`SG_NPER-1:0]                reject_led,
  output logic                               audio_power,
  output logic                               fail_led
);

  typedef struct packed {
    logic [`SG_SEL_W-1:0]      sel_s1;
    logic [`SG_SEL_W-1:0]      sel_s2;
    logic [`SG_NPER-1:0]       att_s1;
    logic [`SG_NPER-1:0]       att_s2;
    logic [`SG_NPER-1:0]       att_prev;
    logic                      fail_s1;
    logic                      fail_s2;
    logic                      failed;
    logic [`SG_NPER-1:0]       auth;
    logic [`SG_NPER-1:0]       reject;
    logic [`SG_NPER-1:0]       live;
    logic                      audio_pwr;
    share_guard_pkg::list_t    block_list;
    share_guard_pkg::list_t    allow_list;
    share_guard_pkg::host_tx_t host_tx;
    share_guard_pkg::per_tx_t  per_tx;
  } state_t;

  state_t q;
  state_t d;

  // Hit in a list of identifiers
  function automatic logic in_list(
    input share_guard_pkg::list_t  list,
    input share_guard_pkg::dev_id_t id
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `SG_LIST_LEN; i++) begin
      if (list[i] == id) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Protocols a port may present
  function automatic logic [`SG_NPROTO-1:0] proto_mask(input int p);
    logic [`SG_NPROTO-1:0] m;
    case (p[`SG_PIDX_W-1:0])
      `SG_PORT_KBD:   m = `SG_PROTO_MASK_KBD;
      `SG_PORT_MOUSE: m = `SG_PROTO_MASK_MOUSE;
      `SG_PORT_DISP0: m = `SG_PROTO_MASK_DISP;
      `SG_PORT_DISP1: m = `SG_PROTO_MASK_DISP;
      `SG_PORT_AUDIO: m = `SG_PROTO_MASK_AUDIO;
      default:        m = '0;
    endcase
    return m;
  endfunction

  // Egress word: internal form or original payload only
  function automatic share_guard_pkg::word_t egress(
    input logic                   conv,
    input share_guard_pkg::word_t w
  );
    share_guard_pkg::word_t o;
    o = w;
    if (!conv) begin
      o.tag = '0;
    end
    return o;
  endfunction

  always_comb begin
    logic                   rise;
    logic                   blocked;
    logic                   allowed;
    logic                   proto_ok;
    logic                   port_ok;
    logic                   halt;
    logic                   ok;
    logic [`SG_NPROTO-1:0]  mask;
    share_guard_pkg::word_t w;
    int                     src;
    int                     dst;
    rise     = 1'b0;
    blocked  = 1'b0;
    allowed  = 1'b0;
    proto_ok = 1'b0;
    port_ok  = 1'b0;
    halt     = 1'b0;
    ok       = 1'b0;
    mask     = '0;
    w        = '0;
    src      = 0;
    dst      = 0;
    d        = q;
    if (ce) begin
      // Pin synchronisers; first stage feeds only the second
      d.sel_s1   = sel_pin;
      d.sel_s2   = q.sel_s1;
      d.att_s1   = attach_pin;
      d.att_s2   = q.att_s1;
      d.att_prev = q.att_s2;
      d.fail_s1  = fail_pin;
      d.fail_s2  = q.fail_s1;

      // Only reset leaves the failure state
      if (q.fail_s2) begin
        d.failed = 1'b1; // [R14]
      end
      // Blocks in the same cycle the fault is seen
      halt = q.failed | q.fail_s2; // [R03]

      // List writes ignored in the fixed build
      if (FILTER_CFG && cfg.we) begin
        if (cfg.allow) begin
          d.allow_list[cfg.idx] = cfg.dev_id; // [R11]
        end else begin
          d.block_list[cfg.idx] = cfg.dev_id; // [R11]
        end
      end

      // Check at power-up and hot-plug: att_prev resets low, so
      // a port already attached at power-up shows a rising edge too.
      for (int p = 0; p < `SG_NPER; p++) begin
        rise = q.att_s2[p] & ~q.att_prev[p];
        blocked  = in_list(q.block_list, desc[p].dev_id); // [R07]
        allowed  = in_list(q.allow_list, desc[p].dev_id);
        mask     = proto_mask(p);
        proto_ok = mask[desc[p].proto]; // [R05]
        port_ok  = MULTI_DISPLAY ||
                   (p[`SG_PIDX_W-1:0] != `SG_PORT_DISP1); // [R12]
        ok = allowed & ~blocked & proto_ok & port_ok; // [R08] [R09]
        if (!q.att_s2[p]) begin
          d.auth[p]   = 1'b0;
          d.reject[p] = 1'b0;
        end else if (rise) begin
          d.auth[p]   = ok; // [R04]
          d.reject[p] = ~ok; // [R06]
        end
        d.live[p] = d.auth[p] & q.att_s2[p] & ~halt; // [R03]
      end

      // Audio supply only for an authorized device
      d.audio_pwr = d.live[`SG_PORT_AUDIO]; // [R10]

      // Peripheral toward the selected host only
      d.host_tx = '0;
      src = int'(per_rx.port);
      if (per_rx.valid && src < `SG_NPER) begin
        if (q.live[src] && !halt) begin // [R01] [R03]
          w.tag  = desc[src].proto; // [R13]
          w.data = per_rx.data;
          d.host_tx.word = egress(OUT_CONVERTED[src], w); // [R13]
          d.host_tx.valid[q.sel_s2] = 1'b1; // [R01] [R02]
        end
      end

      // Host toward a peripheral, from the selected host only;
      // no host output is ever fed from host input.
      d.per_tx = '0;
      dst = int'(host_rx.port);
      if (host_rx.valid[q.sel_s2] && dst < `SG_NPER) begin // [R01] [R02]
        if (q.live[dst] && !halt) begin // [R03]
          w.tag  = desc[dst].proto; // [R13]
          w.data = host_rx.data;
          d.per_tx.word = egress(OUT_CONVERTED[dst], w); // [R13]
          d.per_tx.valid[dst] = 1'b1;
        end
      end
    end
  end

  // Lists start from the built-in defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q            <= '0;
      q.sel_s1     <= `SG_SEL_RST;
      q.sel_s2     <= `SG_SEL_RST;
      q.att_s1     <= `SG_ATTACH_RST;
      q.att_s2     <= `SG_ATTACH_RST;
      q.att_prev   <= `SG_ATTACH_RST;
      q.block_list <= `SG_BLOCK_LIST_RST;
      q.allow_list <= `SG_ALLOW_LIST_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign host_tx     = q.host_tx;
  assign per_tx      = q.per_tx;
  assign port_enable = q.live;
  assign reject_led  = q.reject;
  assign audio_power = q.audio_pwr;
  assign fail_led    = q.failed;

endmodule

`default_nettype wire

// ==== periph_model.sv ====
// Far-side model: peripherals plugging into the guard's ports.
// Assumes the bench sets plug and the next descriptor per port.
`include "share_guard_params.svh"
`default_nettype none
module periph_model (
  // Clock
  input  wire logic                                   clk,
  // Bench control
  input  wire logic [`SG_NPER-1:0]                    plug,
  input  wire share_guard_pkg::desc_t [`SG_NPER-1:0] nd,
  // Toward the guard
  output logic [`SG_NPER-1:0]                         attach_pin,
  output share_guard_pkg::desc_t [`SG_NPER-1:0]      desc
);
  share_guard_pkg::desc_t [`SG_NPER-1:0] hold_q;
  initial begin
    attach_pin = '0;
    hold_q = '0;
  end
  // Descriptor frozen while attached
  always @(posedge clk) begin
    attach_pin <= plug;
    for (int i = 0; i < `SG_NPER; i++) begin
      if (!attach_pin[i]) hold_q[i] <= nd[i];
    end
  end
  // Detached port shows junk, not a stale id
  always_comb begin
    for (int i = 0; i < `SG_NPER; i++) begin
      desc[i] = attach_pin[i] ? hold_q[i] : ~hold_q[i];
    end
  end
endmodule
`default_nettype wire

// ==== guard_monitor.sv ====
// Assertions on the access guard's ports.
// Assumes ce stays high while pins change.
`include "share_guard_params.svh"
`default_nettype none
module guard_monitor (
  // Clock and reset
  input wire logic                            clk,
  input wire logic                            rst_n,
  input wire logic                            ce,
  // Pins
  input wire logic [`SG_NPER-1:0]             attach_pin,
  input wire logic                            fail_pin,
  // Data
  input wire share_guard_pkg::per_rx_t        per_rx,
  input wire share_guard_pkg::host_tx_t       host_tx,
  input wire share_guard_pkg::per_tx_t        per_tx,
  // Status
  input wire logic [`SG_NPER-1:0]             port_enable,
  input wire logic [`SG_NPER-1:0]             reject_led,
  input wire logic                            audio_power,
  input wire logic                            fail_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  one_host_a: assert property ($onehot0(host_tx.valid))
    else $error("two hosts fed");
  fail_block_a: assert property (fail_led |-> host_tx.valid == '0 && per_tx.valid == '0)
    else $error("data in failure");
  fail_hold_a: assert property (fail_led |=> fail_led)
    else $error("failure cleared");
  fail_off_a: assert property (fail_led |-> port_enable == '0 && !audio_power)
    else $error("port live in failure");
  fail_lat_a: assert property ($rose(fail_pin) |-> ##3 fail_led)
    else $error("failure late");
  audio_pwr_a: assert property (audio_power |-> port_enable[4])
    else $error("power to refused audio");
  rej_excl_a: assert property ((port_enable & reject_led) == '0)
    else $error("port both on and refused");
  attach_dec_a: assert property ($rose(attach_pin[0]) && !fail_pin
      |-> ##3 (port_enable[0] || reject_led[0] || fail_led))
    else $error("no attach decision");
  fwd_a: assert property (ce && per_rx.valid && port_enable[per_rx.port]
      |=> host_tx.valid != '0 || fail_led)
    else $error("beat lost");
  no_fwd_a: assert property (ce && (!per_rx.valid || !port_enable[per_rx.port])
      |=> host_tx.valid == '0)
    else $error("beat invented");
  per_dest_a: assert property ((per_tx.valid & ~$past(port_enable)) == '0)
    else $error("beat to closed port");
endmodule
bind peripheral_share_access_guard guard_monitor mon (.clk(clk), .rst_n(rst_n), .ce(ce),
  .attach_pin(attach_pin), .fail_pin(fail_pin), .per_rx(per_rx), .host_tx(host_tx),
  .per_tx(per_tx), .port_enable(port_enable), .reject_led(reject_led),
  .audio_power(audio_power), .fail_led(fail_led));
`default_nettype wire

// ==== peripheral_share_access_guard_tb.sv ====
// Bench for the access guard with default parameters.
// Assumes periph_model and guard_monitor compiled first.
`include "share_guard_params.svh"
`default_nettype none
module peripheral_share_access_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                  clk = 0, rst_n = 0, ce = 1, fail_pin = 0;
  logic [`SG_SEL_W-1:0]                  sel_pin = '0;
  logic [`SG_NPER-1:0]                   plug = '0, attach_pin, port_enable, reject_led;
  logic                                  audio_power, fail_led;
  share_guard_pkg::desc_t [`SG_NPER-1:0] nd = '0, desc;
  share_guard_pkg::cfg_t                 cfg = '0;
  share_guard_pkg::per_rx_t              per_rx = '0;
  share_guard_pkg::host_rx_t             host_rx = '0;
  share_guard_pkg::host_tx_t             host_tx;
  share_guard_pkg::per_tx_t              per_tx;
  int                                    fails = 0, check_count = 0;
  always #4 clk = ~clk;
  periph_model far (.clk(clk), .plug(plug), .nd(nd), .attach_pin(attach_pin), .desc(desc));
  peripheral_share_access_guard uut (.clk(clk), .rst_n(rst_n), .ce(ce), .sel_pin(sel_pin),
    .attach_pin(attach_pin), .fail_pin(fail_pin), .desc(desc), .cfg(cfg), .per_rx(per_rx),
    .host_rx(host_rx), .host_tx(host_tx), .per_tx(per_tx), .port_enable(port_enable),
    .reject_led(reject_led), .audio_power(audio_power), .fail_led(fail_led));
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task beat(logic [2:0] p, logic [3:0] ev, logic [3:0] et);
    per_rx = '{1'b1, p, 8'h5a};
    tick(1);
    chk("host valid", ev, host_tx.valid);
    if (ev != 0) chk("host word", {et, 8'h5a}, host_tx.word);
    per_rx.valid = 1'b0;
    tick(1);
  endtask
  task host(logic [3:0] v, logic [2:0] p, logic [4:0] ev, logic [3:0] et);
    host_rx = '{v, p, 8'ha5};
    tick(1);
    chk("per valid", ev, per_tx.valid);
    if (ev != 0) chk("per word", {et, 8'ha5}, per_tx.word);
    host_rx.valid = '0;
    tick(1);
  endtask
  task replug(int p);
    plug[p] = 1'b0;
    tick(4);
    plug[p] = 1'b1;
    tick(4);
  endtask
  task t_plug;
    nd = {16'h0005, 4'h8, 16'h0003, 4'h1, 16'h0002, 4'h4, 16'hffff, 4'h1, 16'h0001, 4'h1};
    plug = 5'h1f;
    tick(4);
    chk("enable", 5'h05, port_enable);
    chk("reject", 5'h1a, reject_led);
    chk("audio power", 0, audio_power);
    $display("test plug done");
  endtask
  task t_data;
    beat(0, 4'h1, 4'h0);
    beat(2, 4'h1, 4'h4);
    beat(1, 4'h0, 4'h0);
    beat(5, 4'h0, 4'h0);
    host(4'h2, 2, 5'h00, 0);
    host(4'h1, 2, 5'h04, 4'h4);
    host(4'h1, 0, 5'h01, 4'h0);
    sel_pin = 2'h2;
    tick(3);
    beat(0, 4'h4, 4'h0);
    host(4'h1, 0, 5'h00, 0);
    host(4'h4, 0, 5'h01, 4'h0);
    $display("test data done");
  endtask
  task t_power;
    nd[4] = '{16'h0004, 4'h8};
    replug(4);
    chk("audio power", 1, audio_power);
    // Fixed lists: the write must change nothing
    cfg = '{1'b1, 1'b0, 2'h0, 16'h0001};
    tick(1);
    cfg.we = 1'b0;
    replug(0);
    chk("enable", 5'h15, port_enable);
    $display("test power done");
  endtask
  task t_fail;
    fail_pin = 1'b1;
    tick(4);
    chk("fail led", 1, fail_led);
    chk("enable", 0, port_enable);
    beat(0, 4'h0, 4'h0);
    host(4'h4, 0, 5'h00, 0);
    fail_pin = 1'b0;
    tick(4);
    chk("fail led", 1, fail_led);
    $display("test fail done");
  endtask
  task t_reset;
    rst_n = 1'b0;
    tick(2);
    chk("fail led in reset", 0, fail_led);
    rst_n = 1'b1;
    tick(4);
    chk("fail led", 0, fail_led);
    chk("enable", 5'h15, port_enable);
    chk("audio power", 1, audio_power);
    $display("test reset done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(3);
    chk("enable in reset", 0, port_enable);
    rst_n = 1'b1;
    tick(2);
    t_plug();
    t_data();
    t_power();
    t_fail();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
